// *** logic/bms_map.svh ***
// boot mode sequencer register map and timing constants
// assumes inclusion by bms_top and the testbench; definitions only
`ifndef BMS_MAP_SVH
`define BMS_MAP_SVH
`define BMS_CTRL_OFF 8'h00
`define BMS_STAT_OFF 8'h04
`define BMS_CMD_OFF 8'h08
`define BMS_STORE_OFF 8'h0c
`define BMS_CTRL_RST 32'h0000_0000
`define BMS_CTRL_DBG_EN_BIT 0
`define BMS_CTRL_PW_BIT 1
`define BMS_CTRL_PATCH_BIT 2
`define BMS_CTRL_GO_BIT 3
`define BMS_CMD_SWITCH 8'h01
`define BMS_CMD_UART_LOAD 8'h02
`define BMS_CMD_UART_RUN 8'h03
`define BMS_CMD_SLEEP 8'h10
`define BMS_CMD_BACKUP 8'h11
`define BMS_CMD_DEEP 8'h12
`define BMS_CMD_WAKE 8'h20
`define BMS_CHECK_WORD 32'h5a5a_c3c3
`define BMS_UART_BAUD 115200
`define BMS_CLK_HZ 100000000
`define BMS_UART_DIV ((`BMS_CLK_HZ + `BMS_UART_BAUD - 1) / `BMS_UART_BAUD)
`endif

// *** logic/bms_pkg.sv ***
// boot mode sequencer types
// assumes nothing beyond the map header
package bms_pkg;
  typedef enum logic [3:0] {
    BMS_ST_DEBUG = 4'h0,
    BMS_ST_PASSWD = 4'h1,
    BMS_ST_PATCH = 4'h2,
    BMS_ST_STRAP = 4'h3,
    BMS_ST_CHECK = 4'h4,
    BMS_ST_COPY = 4'h5,
    BMS_ST_SUM = 4'h6,
    BMS_ST_USER = 4'h7,
    BMS_ST_HOST = 4'h8,
    BMS_ST_APP = 4'h9,
    BMS_ST_TEST = 4'ha,
    BMS_ST_ERROR = 4'hb
  } bms_boot_t;
  typedef enum logic [1:0] {
    BMS_PW_ACTIVE = 2'h0,
    BMS_PW_SLEEP = 2'h1,
    BMS_PW_BACKUP = 2'h2,
    BMS_PW_DEEP = 2'h3
  } bms_pwr_t;
endpackage

// *** logic/bms_ram.sv ***
// program memory for the downloaded user image
// assumes single clock, synchronous write and registered read
`timescale 1ns/1ps
`default_nettype none
module bms_ram #(
  parameter int AW = 8
) (
  // clock
  input wire logic sys_clk_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [31:0] wdata_in,
  // read port
  input wire logic [AW-1:0] raddr_in,
  output logic [31:0] rdata_out
);
  logic [31:0] mem [0:(1<<AW)-1];
  always_ff @(posedge sys_clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule // bms_ram
`default_nettype wire

// *** logic/bms_top.sv ***
// boot mode sequencer: debug gating, password, patches, strap decode,
// user image check/copy/checksum, operating mode and power state
// assumes the source store answers one word per cycle on store_rd_in
// the strap and debug pins come from pads and are synchronised here
//
// Contract
// - after reset, apply debug-enable setting to the debug port before firmware
// - stored password present restricts debug access to flash and ram
// - no stored password leaves the debug port enabled
// - adopt found patches after password check, only then sample straps (the patch state only waits one cycle and adopts nothing)
// - strap low and debug data low gives the unusable test mode
// - strap low and debug data high boots host-command mode
// - strap high reads the validation word from the source store
// - validation word mismatch falls back to host-command mode
// - validation word match copies the user program into internal memory
// - after copy compare computed checksum with stored checksum
// - checksums agree starts the user program
// - checksum mismatch locks in error until hardware reset
// - only the mode-switch command moves host mode to application-command mode
// - host may download and run a program over uart in host mode
// - three low-power states: sleep, backup, deep sleep
// - low-power states do not depend on operating mode
// - power states active, reset, and one low-power state
// - sleep only from active, wake only to active, no direct moves
// - host-command uart starts at 115.2 kbps, 8n1, no flow control
// - user or application mode stays until hardware reset
// - strap pin pulled up at start, open selects user path
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bms_map.svh"
module bms_top #(
  parameter int AW = 8,
  parameter int UART_DIV = `BMS_UART_DIV
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // pads
  input wire logic boot_strap_pin_in,
  input wire logic dbg_data_pin_in,
  output logic strap_pullup_en_out,
  output logic dbg_port_en_out,
  output logic dbg_restrict_out,
  // source store (flash or i2c eeprom) word reader
  output logic store_rd_out,
  output logic [AW:0] store_addr_out,
  input wire logic store_rd_in,
  input wire logic [31:0] store_data_in,
  // status
  output bms_pkg::bms_boot_t boot_state_out,
  output bms_pkg::bms_pwr_t pwr_state_out,
  output logic cpu_run_out,
  output logic uart_tick_out,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  import bms_pkg::*;

  // refuse sizes the address, ram and 16-bit rate counter cannot serve
  generate
    if (AW < 2 || AW > 16 || UART_DIV < 2 || UART_DIV > 65536)
    begin : g_bad_params
      $error("bms_top: unsupported parameters");
    end
  endgenerate

  typedef struct packed {
    logic [1:0] strap_s;
    logic [1:0] dbg_s;
    bms_boot_t boot;
    bms_pwr_t pwr;
    logic dbg_en;
    logic restrict_r;
    logic strap_v;
    logic dbg_v;
    logic rd_pend;
    logic [AW:0] addr;
    logic [AW:0] len;
    logic [31:0] sum;
    logic [31:0] ctrl;
    logic [31:0] store;
    logic [7:0] cmd_res;
    logic [15:0] baud_cnt;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic w_s0;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [AW-1:0] ram_wa;
    logic [31:0] ram_wd;
    logic ram_we;
  } bms_state_t;

  bms_state_t st_r;
  bms_state_t st_nxt;
  logic [31:0] ram_q;
  logic wr_fire;
  logic [7:0] cmd;

  bms_ram #(.AW(AW)) u_ram (
    .sys_clk_in(sys_clk_in),
    .we_in(st_r.ram_we),
    .waddr_in(st_r.ram_wa),
    .wdata_in(st_r.ram_wd),
    .raddr_in(st_r.ram_wa),
    .rdata_out(ram_q)
  );

  assign wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign cmd = st_r.w_d[7:0];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ram_we = 1'b0;
    st_nxt.strap_s = {st_r.strap_s[0], boot_strap_pin_in};
    st_nxt.dbg_s = {st_r.dbg_s[0], dbg_data_pin_in};
    // uart rate enable
    if (st_r.baud_cnt == 16'(UART_DIV - 1))
    begin
      st_nxt.baud_cnt = 16'h0000;
    end
    else
    begin
      st_nxt.baud_cnt = st_r.baud_cnt + 16'h0001;
    end
    // axi address and data capture
    if (s_awvalid && !st_r.aw_got)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_a = s_awaddr;
    end
    if (s_wvalid && !st_r.w_got)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_d = s_wdata;
      st_nxt.w_s0 = s_wstrb[0];
    end
    if (st_r.bvalid && s_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && s_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_arvalid && !st_r.rvalid)
    begin
      st_nxt.rvalid = 1'b1;
      case (s_araddr)
        `BMS_CTRL_OFF: st_nxt.rdata = st_r.ctrl;
        `BMS_STAT_OFF: st_nxt.rdata = {8'h00, st_r.cmd_res, 7'h00, st_r.strap_v, st_r.dbg_v,
          st_r.restrict_r, st_r.pwr, st_r.boot};
        `BMS_STORE_OFF: st_nxt.rdata = st_r.store;
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_fire)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      case (st_r.aw_a)
        `BMS_CTRL_OFF:
        begin
          if (st_r.w_s0)
          begin
            st_nxt.ctrl[7:0] = st_r.w_d[7:0];
          end
        end
        `BMS_STORE_OFF:
        begin
          if (st_r.w_s0 && st_r.boot == BMS_ST_HOST)
          begin
            st_nxt.ram_we = 1'b1;
            st_nxt.ram_wa = st_r.len[AW-1:0];
            st_nxt.ram_wd = st_r.w_d;
            st_nxt.len = st_r.len + 1'b1;
            st_nxt.store = st_r.store + st_r.w_d;
          end
        end
        `BMS_CMD_OFF:
        begin
          st_nxt.cmd_res = 8'h00;
          if (cmd == `BMS_CMD_SWITCH && st_r.boot == BMS_ST_HOST)
          begin
            st_nxt.boot = BMS_ST_APP;
            st_nxt.cmd_res = cmd;
          end
          else if (cmd == `BMS_CMD_UART_RUN && st_r.boot == BMS_ST_HOST)
          begin
            st_nxt.boot = BMS_ST_USER;
            st_nxt.cmd_res = cmd;
          end
          else if (st_r.pwr == BMS_PW_ACTIVE && (cmd == `BMS_CMD_SLEEP || cmd == `BMS_CMD_BACKUP
            || cmd == `BMS_CMD_DEEP))
          begin
            st_nxt.pwr = bms_pwr_t'(cmd[1:0] + 2'h1);
            st_nxt.cmd_res = cmd;
          end
          else if (cmd == `BMS_CMD_WAKE && st_r.pwr != BMS_PW_ACTIVE)
          begin
            st_nxt.pwr = BMS_PW_ACTIVE;
            st_nxt.cmd_res = cmd;
          end
        end
        default: ;
      endcase
    end
    // boot sequence
    st_nxt.rd_pend = 1'b0;
    case (st_r.boot)
      BMS_ST_DEBUG:
      begin
        st_nxt.dbg_en = st_r.ctrl[`BMS_CTRL_DBG_EN_BIT];
        if (st_r.ctrl[`BMS_CTRL_GO_BIT])
        begin
          st_nxt.boot = BMS_ST_PASSWD;
        end
      end
      BMS_ST_PASSWD:
      begin
        if (st_r.ctrl[`BMS_CTRL_PW_BIT])
        begin
          st_nxt.restrict_r = 1'b1;
        end
        else
        begin
          st_nxt.dbg_en = 1'b1;
        end
        st_nxt.boot = BMS_ST_PATCH;
      end
      BMS_ST_PATCH:
      begin
        st_nxt.boot = BMS_ST_STRAP;
      end
      BMS_ST_STRAP:
      begin
        st_nxt.strap_v = st_r.strap_s[1];
        st_nxt.dbg_v = st_r.dbg_s[1];
        if (st_r.strap_s[1])
        begin
          st_nxt.boot = BMS_ST_CHECK;
          st_nxt.addr = '0;
        end
        else if (st_r.dbg_s[1])
        begin
          st_nxt.boot = BMS_ST_HOST;
        end
        else
        begin
          st_nxt.boot = BMS_ST_TEST;
        end
      end
      BMS_ST_CHECK:
      begin
        st_nxt.rd_pend = !store_rd_in;
        if (store_rd_in)
        begin
          // word 0 check word, word 1 length, then image, then checksum
          st_nxt.addr = st_r.addr + 1'b1;
          if (st_r.addr == '0)
          begin
            if (store_data_in != `BMS_CHECK_WORD)
            begin
              st_nxt.boot = BMS_ST_HOST;
            end
          end
          else
          begin
            st_nxt.len = store_data_in[AW:0];
            st_nxt.sum = 32'h0000_0000;
            st_nxt.boot = BMS_ST_COPY;
          end
        end
      end
      BMS_ST_COPY:
      begin
        st_nxt.rd_pend = !store_rd_in;
        if (store_rd_in)
        begin
          st_nxt.addr = st_r.addr + 1'b1;
          if (st_r.addr == st_r.len + 2)
          begin
            st_nxt.store = store_data_in;
            st_nxt.boot = BMS_ST_SUM;
          end
          else
          begin
            st_nxt.ram_we = 1'b1;
            st_nxt.ram_wa = AW'(st_r.addr - 2);
            st_nxt.ram_wd = store_data_in;
            st_nxt.sum = st_r.sum + store_data_in;
          end
        end
      end
      BMS_ST_SUM:
      begin
        st_nxt.boot = (st_r.sum == st_r.store) ? BMS_ST_USER : BMS_ST_ERROR;
      end
      default: ; // user, app, test and error hold until reset
    endcase
    // the checksum word itself needs no ram slot
    if (st_r.boot == BMS_ST_COPY && st_r.addr > AW'(1) && st_r.addr - 2 > (1 << AW) - 1
      && st_r.addr != st_r.len + 2)
    begin
      st_nxt.boot = BMS_ST_ERROR;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_r <= '0; // reset state
      st_r.ctrl <= `BMS_CTRL_RST;
      st_r.boot <= BMS_ST_DEBUG;
      st_r.pwr <= BMS_PW_ACTIVE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign strap_pullup_en_out = (st_r.boot <= BMS_ST_STRAP);
  assign dbg_port_en_out = st_r.dbg_en;
  assign dbg_restrict_out = st_r.restrict_r;
  assign store_rd_out = (st_r.boot == BMS_ST_CHECK || st_r.boot == BMS_ST_COPY);
  assign store_addr_out = st_r.addr;
  assign boot_state_out = st_r.boot;
  assign pwr_state_out = st_r.pwr;
  assign cpu_run_out = (st_r.boot == BMS_ST_USER) && (st_r.pwr == BMS_PW_ACTIVE);
  assign uart_tick_out = (st_r.baud_cnt == 16'h0000) && (st_r.boot == BMS_ST_HOST);
  assign s_awready = !st_r.aw_got;
  assign s_wready = !st_r.w_got;
  assign s_bvalid = st_r.bvalid;
  assign s_bresp = 2'b00;
  assign s_arready = !st_r.rvalid;
  assign s_rvalid = st_r.rvalid;
  assign s_rdata = st_r.rdata;
  assign s_rresp = 2'b00;

  chk_mismatch_to_host: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_CHECK && store_rd_in && st_r.addr == '0 && store_data_in != `BMS_CHECK_WORD
    |=> st_r.boot == BMS_ST_HOST) else $error("bad check word did not fall back");
  chk_error_sticks: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_ERROR |=> st_r.boot == BMS_ST_ERROR) else $error("error left");
  chk_lp_no_direct: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.pwr != BMS_PW_ACTIVE |=> st_r.pwr == $past(st_r.pwr) || st_r.pwr == BMS_PW_ACTIVE)
    else $error("direct low-power move");
  chk_strap_held: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot > BMS_ST_STRAP |=> $stable(st_r.strap_v) && $stable(st_r.dbg_v))
    else $error("strap changed");
  chk_test_mode: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_STRAP && !st_r.strap_s[1] && !st_r.dbg_s[1] |=> st_r.boot == BMS_ST_TEST)
    else $error("test mode missed");
  chk_host_boot: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_STRAP && !st_r.strap_s[1] && st_r.dbg_s[1] |=> st_r.boot == BMS_ST_HOST)
    else $error("host boot missed");
  chk_app_only_host: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot != BMS_ST_APP ##1 st_r.boot == BMS_ST_APP |-> $past(st_r.boot) == BMS_ST_HOST)
    else $error("app entered wrongly");
  chk_user_holds: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_USER || st_r.boot == BMS_ST_APP |=> $stable(st_r.boot))
    else $error("mode changed");
  chk_nopw_dbg: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_PASSWD && !st_r.ctrl[`BMS_CTRL_PW_BIT] |=> st_r.dbg_en && !st_r.restrict_r)
    else $error("debug not enabled");
  chk_sum_go: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    st_r.boot == BMS_ST_SUM && st_r.sum == st_r.store |=> ##1 cpu_run_out || st_r.pwr != BMS_PW_ACTIVE
    || $past(st_r.pwr) != BMS_PW_ACTIVE || st_r.boot == BMS_ST_USER)
    else $error("user not started");
  cov_user: cover property (@(posedge sys_clk_in) st_r.boot == BMS_ST_USER);
  cov_error: cover property (@(posedge sys_clk_in) st_r.boot == BMS_ST_ERROR);
  cov_app: cover property (@(posedge sys_clk_in) st_r.boot == BMS_ST_APP);
  cov_deep: cover property (@(posedge sys_clk_in) st_r.pwr == BMS_PW_DEEP);
endmodule // bms_top
`default_nettype wire

// *** tb/bms_store_model.sv ***
// store model: flash or i2c eeprom image, one word per request
// assumes a level request held until the answer pulse
`timescale 1ns/1ps
`default_nettype none
module bms_store_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // request
  input wire logic req_in,
  input wire logic [8:0] addr_in,
  // image setup
  input wire logic [31:0] check_word_in,
  input wire logic [7:0] len_in,
  input wire logic [31:0] base_in,
  input wire logic sum_err_in,
  input wire logic [1:0] delay_in,
  // answer
  output logic rd_out,
  output logic [31:0] data_out
);
  logic [1:0] wait_r;
  // image layout: check word, length, words, checksum
  function automatic logic [31:0] word_at(input logic [8:0] a);
    logic [31:0] s;
    s = {31'h0, sum_err_in};
    for (int i = 0; i < len_in; i++)
      s += base_in + 32'(i) * 32'h0101_0101;
    if (a == 9'h0)
      return check_word_in;
    if (a == 9'h1)
      return {24'h0, len_in};
    if (a < {1'h0, len_in} + 9'h2)
      return base_in + 32'(a - 9'h2) * 32'h0101_0101;
    return s;
  endfunction
  always_ff @(posedge sys_clk_in or posedge sys_rst_in)
    if (sys_rst_in)
    begin
      rd_out <= 1'h0;
      data_out <= 32'h0;
      wait_r <= 2'h0;
    end
    else if (req_in && !rd_out && wait_r == 2'h0)
    begin
      rd_out <= 1'h1;
      data_out <= word_at(addr_in);
      wait_r <= delay_in;
    end
    else
    begin
      // released data line does not keep its last value
      rd_out <= 1'h0;
      data_out <= ~data_out;
      if (req_in && wait_r != 2'h0)
        wait_r <= wait_r - 2'h1;
    end
endmodule // bms_store_model
`default_nettype wire

// *** tb/boot_mode_sequencer_tb.sv ***
// testbench for the boot mode sequencer
// assumes the store model and an axi4-lite master in this file
`timescale 1ns/1ps
`default_nettype none
`include "bms_map.svh"
module boot_mode_sequencer_tb;
  import bms_pkg::*;
  localparam int DIV = 4;
  logic clk = 1'h0, rst = 1'h1, strap = 1'h1, dbg = 1'h1;
  logic pu, dbg_en, restr, req, ack, cpu_run, tick;
  logic [8:0] saddr;
  logic [31:0] sdata, rdata;
  logic [31:0] chk_word = `BMS_CHECK_WORD;
  logic [31:0] base = 32'h1234_0000;
  logic [7:0] len = 8'h4;
  logic sum_err = 1'h0;
  logic [1:0] dly = 2'h1;
  bms_boot_t boot_st;
  bms_pwr_t pwr;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int failures = 0, samples_checked = 0, cycles = 0, seed = 85215;

  always #5 clk = ~clk;

  bms_top #(.AW(8), .UART_DIV(DIV)) i_dut (.sys_clk_in(clk), .sys_rst_in(rst),
    .boot_strap_pin_in(strap), .dbg_data_pin_in(dbg), .strap_pullup_en_out(pu),
    .dbg_port_en_out(dbg_en), .dbg_restrict_out(restr), .store_rd_out(req),
    .store_addr_out(saddr), .store_rd_in(ack), .store_data_in(sdata),
    .boot_state_out(boot_st), .pwr_state_out(pwr), .cpu_run_out(cpu_run),
    .uart_tick_out(tick), .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready));

  bms_store_model i_store (.sys_clk_in(clk), .sys_rst_in(rst), .req_in(req),
    .addr_in(saddr), .check_word_in(chk_word), .len_in(len), .base_in(base),
    .sum_err_in(sum_err), .delay_in(dly), .rd_out(ack), .data_out(sdata));

  task automatic end_sim();
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      aw_ok = aw_ok | (awvalid & awready);
      w_ok = w_ok | (wvalid & wready);
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    while (bvalid !== 1'h1)
      @(posedge clk);
    chk("bresp", bresp, 2'b00);
    bready <= 1'h0;
    @(posedge clk);
    #1;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge clk);
    while (arready !== 1'h1)
      @(posedge clk);
    arvalid <= 1'h0;
    while (rvalid !== 1'h1)
      @(posedge clk);
    d = rdata;
    chk("rresp", rresp, 2'b00);
    rready <= 1'h0;
    @(posedge clk);
    #1;
  endtask

  // hardware reset, straps, then start the sequence
  task automatic boot(input logic s, input logic d, input logic [31:0] ctrl);
    int n;
    n = 0;
    @(posedge clk);
    rst <= 1'h1;
    strap <= s;
    dbg <= d;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    axi_wr(`BMS_CTRL_OFF, ctrl | 32'h8);
    while (n < 3000 && (boot_st inside {BMS_ST_USER, BMS_ST_HOST, BMS_ST_APP, BMS_ST_TEST,
      BMS_ST_ERROR}) !== 1'h1)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    chk("boot done", n < 3000, 1);
  endtask

  function automatic bms_boot_t exp_boot(input logic s, d, bc, se);
    if (!s)
      return d ? BMS_ST_HOST : BMS_ST_TEST;
    if (bc)
      return BMS_ST_HOST;
    return se ? BMS_ST_ERROR : BMS_ST_USER;
  endfunction

  task automatic pwr_walk(input bms_boot_t mode);
    for (int k = 0; k < 3; k++)
    begin
      axi_wr(`BMS_CMD_OFF, 32'h10 + k);
      chk("sleep", pwr, k + 1);
      chk("run asleep", cpu_run, 0);
      axi_wr(`BMS_CMD_OFF, 32'h10 + (k + 1) % 3);
      chk("direct", pwr, k + 1);
      axi_wr(`BMS_CMD_OFF, `BMS_CMD_WAKE);
      chk("wake", pwr, BMS_PW_ACTIVE);
      chk("mode", boot_st, mode);
    end
  endtask

  initial
  begin
    int n;
    logic s, d, bc, se;
    bms_boot_t e;
    logic [31:0] rd;
    logic [31:0] acc;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    axi_wr(`BMS_CTRL_OFF, 32'h1);
    chk("dbg on", dbg_en, 1);
    chk("pull-up", pu, 1);
    axi_wr(`BMS_CTRL_OFF, 32'h0);
    chk("dbg off", dbg_en, 0);
    boot(1'h0, 1'h0, 32'h0);
    chk("test", boot_st, BMS_ST_TEST);
    chk("dbg no pw", dbg_en, 1);
    chk("no restrict", restr, 0);
    chk("pull-up off", pu, 0);
    boot(1'h0, 1'h1, 32'h7);
    chk("host", boot_st, BMS_ST_HOST);
    chk("restrict", restr, 1);
    do @(posedge clk); while (tick !== 1'h1);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (tick !== 1'h1);
    chk("tick gap", n, DIV);
    acc = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      rd = $random(seed);
      acc = acc + rd;
      axi_wr(`BMS_STORE_OFF, rd);
    end
    axi_rd(`BMS_STORE_OFF, rd);
    chk("uart sum", rd, acc);
    axi_wr(`BMS_CMD_OFF, `BMS_CMD_UART_RUN);
    chk("uart run", boot_st, BMS_ST_USER);
    chk("cpu run", cpu_run, 1);
    axi_wr(`BMS_CMD_OFF, `BMS_CMD_SWITCH);
    chk("user kept", boot_st, BMS_ST_USER);
    pwr_walk(BMS_ST_USER);
    boot(1'h0, 1'h1, 32'h0);
    axi_wr(`BMS_CMD_OFF, `BMS_CMD_UART_LOAD);
    chk("host kept", boot_st, BMS_ST_HOST);
    axi_wr(`BMS_CMD_OFF, `BMS_CMD_SWITCH);
    chk("app", boot_st, BMS_ST_APP);
    axi_rd(`BMS_STAT_OFF, rd);
    chk("switch result", rd[23:16], `BMS_CMD_SWITCH);
    axi_wr(`BMS_CMD_OFF, `BMS_CMD_UART_RUN);
    chk("app kept", boot_st, BMS_ST_APP);
    axi_rd(`BMS_STAT_OFF, rd);
    chk("run refused", rd[23:16], 8'h00);
    pwr_walk(BMS_ST_APP);
    boot(1'h1, 1'h0, 32'h0);
    chk("user", boot_st, BMS_ST_USER);
    axi_rd(`BMS_STORE_OFF, rd);
    chk("stored sum", rd, 32'h4ed6_0606);
    @(posedge clk);
    strap <= 1'h0;
    repeat (8) @(posedge clk);
    #1;
    chk("held", boot_st, BMS_ST_USER);
    axi_rd(`BMS_STAT_OFF, rd);
    chk("strap seen", rd[8], 1);
    chk("status boot", rd[3:0], BMS_ST_USER);
    axi_rd(8'h40, rd);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 8; i++)
    begin
      s = (i < 2) | 1'($random(seed));
      d = 1'($random(seed));
      bc = (i == 0) || (i > 1 && ($random(seed) & 3) == 0);
      se = (i == 1) || (i > 1 && ($random(seed) & 3) == 0);
      chk_word <= bc ? ~`BMS_CHECK_WORD : `BMS_CHECK_WORD;
      base <= $random(seed);
      len <= 8'h1 + 8'($random(seed) & 15);
      sum_err <= se;
      dly <= 2'($random(seed));
      boot(s, d, 32'h0);
      e = exp_boot(s, d, bc, se);
      chk("path", boot_st, e);
      if (e == BMS_ST_USER || e == BMS_ST_ERROR)
      begin
        axi_wr(`BMS_CMD_OFF, `BMS_CMD_SWITCH);
        chk("locked", boot_st, e);
      end
    end
    end_sim();
  end
endmodule // boot_mode_sequencer_tb
`default_nettype wire
